// ### rtl/ioxp_pkg.sv
// Shared constants and types of the sixteen-bit I/O expander
package ioxp_pkg;

	// ==========================================================
	// Register pointer values and groups
	localparam logic [2:0] REG_IN0  = 3'h0;
	localparam logic [2:0] REG_IN1  = 3'h1;
	localparam logic [2:0] REG_OUT0 = 3'h2;
	localparam logic [2:0] REG_OUT1 = 3'h3;
	localparam logic [2:0] REG_POL0 = 3'h4;
	localparam logic [2:0] REG_POL1 = 3'h5;
	localparam logic [2:0] REG_CFG0 = 3'h6;
	localparam logic [2:0] REG_CFG1 = 3'h7;
	localparam logic [1:0] GRP_IN   = 2'h0;
	localparam logic [1:0] GRP_OUT  = 2'h1;
	localparam logic [1:0] GRP_POL  = 2'h2;
	localparam logic [1:0] GRP_CFG  = 2'h3;

	// ==========================================================
	// Values after reset and the default high address bits
	localparam logic [7:0] OUT_RST  = 8'hFF;
	localparam logic [7:0] POL_RST  = 8'h00;
	localparam logic [7:0] CFG_RST  = 8'hFF;
	localparam logic [3:0] ADDR_HI  = 4'h5; // Arbitrary high address bits

	// ==========================================================
	// Timing
	localparam int SCL_MAX_HZ   = 400_000;
	localparam int SCL_HALF_NS  = 1_000_000_000 / (2 * SCL_MAX_HZ);
	localparam int LINK_SAMPLES = 8;
	localparam int LINK_CLK_NS  = 30;

	// ==========================================================
	// Bus engine states
	typedef enum logic [2:0] {
		LK_IDLE,
		LK_RX,
		LK_RXACK,
		LK_TXLOAD,
		LK_TX,
		LK_TXACK
	} ioxp_link_e;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_CMD,
		PH_DATA
	} ioxp_phase_e;

endpackage

// ### rtl/ioxp_sync.sv
// Three-stage synchroniser with agreement filter
module ioxp_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	if (W < 1)
	begin : g_chk
		$error("ioxp_sync: width must be positive");
	end

	// ==========================================================
	// Stages; a bit changes once stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s1  <= INIT;
			s2  <= INIT;
			s3  <= INIT;
			q_o <= INIT;
		end
		else
		begin
			s1  <= d_i;
			s2  <= s1;
			s3  <= s2;
			q_o <= (s2 & s3) | (q_o & (s2 ^ s3));
		end
	end

endmodule

// ### rtl/ioxp_port.sv
// One eight-pin port: output, polarity and direction latches, change detect
module ioxp_port #(
	parameter int PORT_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [PORT_W-1:0] pin_i,
	input  wire logic              wr_i,
	input  wire logic [1:0]        grp_i,
	input  wire logic [PORT_W-1:0] data_i,
	input  wire logic              cap_i,
	output logic      [PORT_W-1:0] out_o,
	output logic      [PORT_W-1:0] pol_o,
	output logic      [PORT_W-1:0] cfg_o,
	output logic      [PORT_W-1:0] in_o,
	output logic                   chg_o
);
	logic [PORT_W-1:0] snap;

	if (PORT_W != 8)
	begin : g_chk
		$error("ioxp_port: ports are one byte wide");
	end

	assign in_o = pin_i ^ pol_o;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			out_o <= ioxp_pkg::OUT_RST;
			pol_o <= ioxp_pkg::POL_RST;
			cfg_o <= ioxp_pkg::CFG_RST;
			snap  <= pin_i;
			chg_o <= 1'b0;
		end
		else
		begin
			if (wr_i && grp_i == ioxp_pkg::GRP_OUT)
				out_o <= data_i;
			if (wr_i && grp_i == ioxp_pkg::GRP_POL)
				pol_o <= data_i;
			if (wr_i && grp_i == ioxp_pkg::GRP_CFG)
				cfg_o <= data_i;
			if (cap_i)
				snap <= pin_i;
			chg_o <= (pin_i != snap);
		end
	end

endmodule

// ### rtl/ioxp_top.sv
// Sixteen-bit I/O expander: bus slave on the link clock, ports on the reference clock
module ioxp_top #(
	parameter logic [3:0] SLAVE_ADDR_HI = ioxp_pkg::ADDR_HI,
	parameter int         LINK_NS       = ioxp_pkg::LINK_CLK_NS
) (
	input  wire logic       REF_CLK_I,
	input  wire logic       RESETN_I,
	input  wire logic       LINK_CLK_I,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_O,
	input  wire logic       ADDR_STRAP_BIT0_I,
	input  wire logic       ADDR_STRAP_BIT1_I,
	input  wire logic       ADDR_STRAP_BIT2_I,
	input  wire logic [7:0] GPIO_LO_PIN_I,
	output logic      [7:0] GPIO_LO_PIN_O,
	output logic      [7:0] GPIO_LO_PIN_OE_O,
	input  wire logic [7:0] GPIO_HI_PIN_I,
	output logic      [7:0] GPIO_HI_PIN_O,
	output logic      [7:0] GPIO_HI_PIN_OE_O,
	output logic            INT_N_O,
	output logic            INT_N_OE_O
);
	// Link must sample each SCL half period several times
	if (LINK_NS * ioxp_pkg::LINK_SAMPLES > ioxp_pkg::SCL_HALF_NS)
	begin : g_chk
		$error("ioxp_top: link clock too slow for Fast-mode");
	end

	function automatic logic [2:0] pair_next(input logic [2:0] p);
		pair_next = {p[2:1], ~p[0]};
	endfunction

	// ==========================================================
	// Reference domain: pins and request toggles
	logic [15:0]      pin_q;
	logic [1:0]       tgl_q;
	logic [1:0]       tgl_prev;
	logic             wr_tgl;
	logic             rd_tgl;
	logic [2:0]       req_idx;
	logic [7:0]       req_data;
	logic [7:0]       rd_data;
	logic             ack_tgl;
	logic             int_drive;
	logic [1:0][7:0]  out_v;
	logic [1:0][7:0]  pol_v;
	logic [1:0][7:0]  cfg_v;
	logic [1:0][7:0]  in_v;
	logic [1:0]       chg;

	// Pin filter runs through reset so the snapshot loads real levels
	ioxp_sync #(.W(16), .INIT(16'h0000)) u_pin_sync (
		.clk_i   (REF_CLK_I),
		.rst_n_i (1'b1),
		.d_i     ({GPIO_HI_PIN_I, GPIO_LO_PIN_I}),
		.q_o     (pin_q)
	);

	ioxp_sync #(.W(2), .INIT(2'h0)) u_tgl_sync (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RESETN_I),
		.d_i     ({rd_tgl, wr_tgl}),
		.q_o     (tgl_q)
	);

	wire       wr_evt = tgl_q[0] ^ tgl_prev[0];
	wire       rd_evt = tgl_q[1] ^ tgl_prev[1];
	wire [1:0] grp    = req_idx[2:1];
	wire       psel   = req_idx[0];
	wire       is_in  = (grp == ioxp_pkg::GRP_IN);
	wire [7:0] rd_mux = is_in ? in_v[psel] :
		(grp == ioxp_pkg::GRP_OUT) ? out_v[psel] :
		(grp == ioxp_pkg::GRP_POL) ? pol_v[psel] : cfg_v[psel];

	// Two ports, one register byte each per group
	for (genvar p = 0; p < 2; p++)
	begin : g_port
		ioxp_port #(.PORT_W(8)) u_port (
			.clk_i            (REF_CLK_I),
			.rst_n_i          (RESETN_I),
			.pin_i            (pin_q[p*8 +: 8]),
			.wr_i             (wr_evt && psel == 1'(p)),
			.grp_i            (grp),
			.data_i           (req_data),
			.cap_i            (rd_evt && is_in && psel == 1'(p)),
			.out_o            (out_v[p]),
			.pol_o            (pol_v[p]),
			.cfg_o            (cfg_v[p]),
			.in_o             (in_v[p]),
			.chg_o            (chg[p])
		);
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RESETN_I)
		begin
			tgl_prev  <= 2'h0;
			rd_data   <= 8'h00;
			ack_tgl   <= 1'b0;
			int_drive <= 1'b0;
		end
		else
		begin
			tgl_prev  <= tgl_q;
			int_drive <= |chg;
			if (rd_evt)
			begin
				rd_data <= rd_mux;
				ack_tgl <= ~ack_tgl;
			end
		end
	end

	assign GPIO_LO_PIN_O    = out_v[0];
	assign GPIO_HI_PIN_O    = out_v[1];
	assign GPIO_LO_PIN_OE_O = ~cfg_v[0];
	assign GPIO_HI_PIN_OE_O = ~cfg_v[1];
	assign INT_N_O          = 1'b0;
	assign INT_N_OE_O       = int_drive;

	// ==========================================================
	// Link domain: reset, pin filters, edges
	logic             lrst1;
	logic             lrst_n;
	logic [1:0]       bus_q;
	logic [2:0]       strap_q;
	logic             ack_q;
	logic             ack_prev;
	logic             scl_prev;
	logic             sda_prev;

	always_ff @(posedge LINK_CLK_I)
	begin
		lrst1  <= RESETN_I;
		lrst_n <= lrst1;
	end

	ioxp_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
		.clk_i   (LINK_CLK_I),
		.rst_n_i (lrst_n),
		.d_i     ({SCL_I, SDA_I}),
		.q_o     (bus_q)
	);

	ioxp_sync #(.W(3), .INIT(3'h0)) u_strap_sync (
		.clk_i   (LINK_CLK_I),
		.rst_n_i (lrst_n),
		.d_i     ({ADDR_STRAP_BIT2_I, ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT0_I}),
		.q_o     (strap_q)
	);

	ioxp_sync #(.W(1), .INIT(1'h0)) u_ack_sync (
		.clk_i   (LINK_CLK_I),
		.rst_n_i (lrst_n),
		.d_i     (ack_tgl),
		.q_o     (ack_q)
	);

	wire scl_q     = bus_q[1];
	wire sda_q     = bus_q[0];
	wire scl_rise  = scl_q & ~scl_prev;
	wire scl_fall  = ~scl_q & scl_prev;
	wire bus_start = scl_q & scl_prev & sda_prev & ~sda_q;
	wire bus_stop  = scl_q & scl_prev & ~sda_prev & sda_q;
	wire ack_evt   = ack_q ^ ack_prev;

	// ==========================================================
	// Link domain: byte engine
	ioxp_pkg::ioxp_link_e  state;
	ioxp_pkg::ioxp_link_e  next_state;
	ioxp_pkg::ioxp_phase_e phase;
	ioxp_pkg::ioxp_phase_e next_phase;
	logic [3:0]            cnt;
	logic [3:0]            next_cnt;
	logic [7:0]            sh;
	logic [7:0]            next_sh;
	logic [2:0]            ptr;
	logic [2:0]            next_ptr;
	logic                  rw;
	logic                  next_rw;
	logic                  mack;
	logic                  next_mack;
	logic                  drive;
	logic                  next_drive;
	logic                  next_wr_tgl;
	logic                  next_rd_tgl;
	logic [2:0]            next_idx;
	logic [7:0]            next_data;

	wire       addr_hit = (sh[7:1] == {SLAVE_ADDR_HI, strap_q});
	wire       byte_end = scl_fall && cnt == 4'd8;
	wire [2:0] sh_low   = sh[2:0];

	always_comb
	begin
		next_state  = state;
		next_phase  = phase;
		next_cnt    = cnt;
		next_sh     = sh;
		next_ptr    = ptr;
		next_rw     = rw;
		next_mack   = mack;
		next_drive  = drive;
		next_wr_tgl = wr_tgl;
		next_rd_tgl = rd_tgl;
		next_idx    = req_idx;
		next_data   = req_data;
		if (bus_start)
		begin
			next_state = ioxp_pkg::LK_RX;
			next_phase = ioxp_pkg::PH_ADDR;
			next_cnt   = 4'h0;
			next_drive = 1'b0;
		end
		else if (bus_stop)
		begin
			next_state = ioxp_pkg::LK_IDLE;
			next_drive = 1'b0;
		end
		else
		begin
			unique case (state)
				ioxp_pkg::LK_IDLE:
					next_state = ioxp_pkg::LK_IDLE;
				ioxp_pkg::LK_RX:
					if (scl_rise)
					begin
						next_sh  = {sh[6:0], sda_q};
						next_cnt = cnt + 4'h1;
					end
					else if (byte_end)
					begin
						next_cnt   = 4'h0;
						next_drive = 1'b1;
						next_state = ioxp_pkg::LK_RXACK;
						unique case (phase)
							ioxp_pkg::PH_ADDR:
							begin
								next_rw = sh[0];
								if (!addr_hit)
								begin
									next_drive = 1'b0;
									next_state = ioxp_pkg::LK_IDLE;
								end
							end
							ioxp_pkg::PH_CMD:
								next_ptr = sh[2:0];
							default:
							begin
								next_idx    = ptr;
								next_data   = sh;
								next_wr_tgl = ~wr_tgl;
								next_ptr    = pair_next(ptr);
							end
						endcase
					end
				ioxp_pkg::LK_RXACK:
					if (scl_fall)
					begin
						next_drive = 1'b0;
						if (phase == ioxp_pkg::PH_ADDR && rw)
						begin
							next_idx    = ptr;
							next_rd_tgl = ~rd_tgl;
							next_ptr    = pair_next(ptr);
							next_phase  = ioxp_pkg::PH_DATA;
							next_state  = ioxp_pkg::LK_TXLOAD;
						end
						else
						begin
							next_phase = (phase == ioxp_pkg::PH_ADDR) ?
								ioxp_pkg::PH_CMD : ioxp_pkg::PH_DATA;
							next_state = ioxp_pkg::LK_RX;
						end
					end
				ioxp_pkg::LK_TXLOAD:
					if (ack_evt)
					begin
						next_sh    = rd_data;
						next_drive = ~rd_data[7];
						next_cnt   = 4'h0;
						next_state = ioxp_pkg::LK_TX;
					end
				ioxp_pkg::LK_TX:
					if (scl_fall)
					begin
						if (cnt == 4'd7)
						begin
							next_drive = 1'b0;
							next_state = ioxp_pkg::LK_TXACK;
						end
						else
						begin
							next_sh    = {sh[6:0], 1'b0};
							next_drive = ~sh[6];
							next_cnt   = cnt + 4'h1;
						end
					end
				ioxp_pkg::LK_TXACK:
					if (scl_rise)
						next_mack = ~sda_q;
					else if (scl_fall)
					begin
						if (mack)
						begin
							next_idx    = ptr;
							next_rd_tgl = ~rd_tgl;
							next_ptr    = pair_next(ptr);
							next_state  = ioxp_pkg::LK_TXLOAD;
						end
						else
							next_state = ioxp_pkg::LK_IDLE;
					end
				default:
					next_state = ioxp_pkg::LK_IDLE;
			endcase
		end
	end

	always_ff @(posedge LINK_CLK_I)
	begin
		if (!lrst_n)
		begin
			state    <= ioxp_pkg::LK_IDLE;
			phase    <= ioxp_pkg::PH_ADDR;
			cnt      <= 4'h0;
			sh       <= 8'h00;
			ptr      <= ioxp_pkg::REG_IN0;
			rw       <= 1'b0;
			mack     <= 1'b0;
			drive    <= 1'b0;
			wr_tgl   <= 1'b0;
			rd_tgl   <= 1'b0;
			req_idx  <= ioxp_pkg::REG_IN0;
			req_data <= 8'h00;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			ack_prev <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			phase    <= next_phase;
			cnt      <= next_cnt;
			sh       <= next_sh;
			ptr      <= next_ptr;
			rw       <= next_rw;
			mack     <= next_mack;
			drive    <= next_drive;
			wr_tgl   <= next_wr_tgl;
			rd_tgl   <= next_rd_tgl;
			req_idx  <= next_idx;
			req_data <= next_data;
			scl_prev <= scl_q;
			sda_prev <= sda_q;
			ack_prev <= ack_q;
		end
	end

	assign SDA_O    = 1'b0;
	assign SDA_OE_O = drive;

	// ==========================================================
	// Checks
	wire [7:0] pin_lo = pin_q[7:0];
	wire [7:0] pol_lo = pol_v[0];

	property p_int_release;
		@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!(|chg) ##1 !(|chg) |=> !INT_N_OE_O;
	endproperty
	a_int_release: assert property (p_int_release) else $error("interrupt held");

	property p_int_od;
		@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(|chg) |=> (INT_N_OE_O && INT_N_O == 1'b0);
	endproperty
	a_int_od: assert property (p_int_od) else $error("interrupt not pulled low");

	property p_reset_vals;
		@(posedge REF_CLK_I)
		!RESETN_I |=> (out_v == {2{ioxp_pkg::OUT_RST}} && pol_v == {2{ioxp_pkg::POL_RST}});
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

	property p_hiz_start;
		@(posedge REF_CLK_I)
		!RESETN_I |=> (GPIO_LO_PIN_OE_O == 8'h00 && GPIO_HI_PIN_OE_O == 8'h00);
	endproperty
	a_hiz_start: assert property (p_hiz_start) else $error("pin driven at reset");

	property p_out_hold;
		@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!(wr_evt && grp == ioxp_pkg::GRP_OUT) |=> $stable(out_v);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output latch moved");

	property p_in_ro;
		@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(wr_evt && is_in) |=> ($stable(out_v) && $stable(pol_v) && $stable(cfg_v));
	endproperty
	a_in_ro: assert property (p_in_ro) else $error("input write had effect");

	property p_pol_read;
		@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(rd_evt && req_idx == ioxp_pkg::REG_IN0) |=>
			rd_data == ($past(pin_lo) ^ $past(pol_lo));
	endproperty
	a_pol_read: assert property (p_pol_read) else $error("polarity not applied");

	property p_read_clears;
		@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(rd_evt && req_idx == ioxp_pkg::REG_IN0) ##1 $stable(pin_lo) |=> !chg[0];
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read kept change");

	property p_cmd_ptr;
		@(posedge LINK_CLK_I) disable iff (!lrst_n)
		(state == ioxp_pkg::LK_RX && phase == ioxp_pkg::PH_CMD && byte_end
			&& !bus_start && !bus_stop) |=> ptr == $past(sh_low);
	endproperty
	a_cmd_ptr: assert property (p_cmd_ptr) else $error("pointer not loaded");

	property p_read_dir;
		@(posedge LINK_CLK_I) disable iff (!lrst_n)
		(state == ioxp_pkg::LK_RXACK && phase == ioxp_pkg::PH_ADDR && rw && scl_fall
			&& !bus_start && !bus_stop) |=> state == ioxp_pkg::LK_TXLOAD;
	endproperty
	a_read_dir: assert property (p_read_dir) else $error("read not started");

	property p_addr_miss;
		@(posedge LINK_CLK_I) disable iff (!lrst_n)
		(state == ioxp_pkg::LK_RX && phase == ioxp_pkg::PH_ADDR && byte_end && !addr_hit
			&& !bus_start && !bus_stop) |=> (!SDA_OE_O && state == ioxp_pkg::LK_IDLE);
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

endmodule

// ### test/ioxp_master_model.sv
// Bus master model driving the expander's serial clock and data lines
module ioxp_master_model
(
	input  wire logic link_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Bus timing in link cycles: 1320 ns low, 1200 ns high
	localparam int T_LOW  = 44;
	localparam int T_HIGH = 40;

	initial
	begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge link_clk_i);
	endtask

	// ==========================================================
	// Bus conditions and bits
	task automatic start_cond();
		tick(4);
		sda_low_o <= 1'b0;
		tick(T_LOW - 4);
		scl_o <= 1'b1;
		tick(T_HIGH);
		sda_low_o <= 1'b1;
		tick(T_HIGH);
		scl_o <= 1'b0;
	endtask

	task automatic stop_cond();
		tick(4);
		sda_low_o <= 1'b1;
		tick(T_LOW - 4);
		scl_o <= 1'b1;
		tick(T_HIGH);
		sda_low_o <= 1'b0;
		tick(T_HIGH);
	endtask

	// Data settles well after the clock fall, sampled mid high phase
	task automatic bit_xfer(input logic b, output logic r);
		tick(4);
		sda_low_o <= !b;
		tick(T_LOW - 4);
		scl_o <= 1'b1;
		tick(T_HIGH / 2);
		r = sda_i;
		tick(T_HIGH - T_HIGH / 2);
		scl_o <= 1'b0;
	endtask

	// Eight bits, most significant first, then the acknowledge bit
	task automatic byte_xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			bit_xfer(d[i], q[i]);
		end
		bit_xfer(last, ack);
	endtask

	// ==========================================================
	// Register pair transfers
	task automatic write_pair(input logic [6:0] addr, input logic [2:0] ptr,
		input logic [7:0] d0, input logic [7:0] d1, output logic [3:0] acks);
		logic [7:0] q;
		start_cond();
		byte_xfer({addr, 1'b0}, 1'b1, q, acks[3]);
		byte_xfer({5'h00, ptr}, 1'b1, q, acks[2]);
		byte_xfer(d0, 1'b1, q, acks[1]);
		byte_xfer(d1, 1'b1, q, acks[0]);
		stop_cond();
	endtask

	task automatic read_pair(input logic [6:0] addr, input logic [2:0] ptr,
		output logic [7:0] d0, output logic [7:0] d1, output logic [2:0] acks);
		logic [7:0] q;
		logic       m;
		start_cond();
		byte_xfer({addr, 1'b0}, 1'b1, q, acks[2]);
		byte_xfer({5'h00, ptr}, 1'b1, q, acks[1]);
		start_cond();
		byte_xfer({addr, 1'b1}, 1'b1, q, acks[0]);
		byte_xfer(8'hFF, 1'b0, d0, m);
		byte_xfer(8'hFF, 1'b1, d1, m);
		stop_cond();
	endtask
endmodule

// ### test/i2c_sixteen_bit_io_expander_test.sv
// Self-checking bench of the sixteen-bit I/O expander
`define CHK(act, exp) \
	begin \
		checked++; \
		if ((act) !== (exp)) \
		begin \
			err_count++; \
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (act), (exp)); \
		end \
	end

module i2c_sixteen_bit_io_expander_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [6:0] DEV = {ioxp_pkg::ADDR_HI, 3'h5};

	logic       ref_clk;
	logic       link_clk;
	logic       resetn;
	logic [2:0] strap;
	logic [7:0] ext_lo;
	logic [7:0] ext_hi;
	wire        scl;
	wire        sda_pull;
	logic       sda_oe;
	logic       sda_o;
	logic [7:0] lo_o;
	logic [7:0] lo_oe;
	logic [7:0] hi_o;
	logic [7:0] hi_oe;
	logic       int_n;
	logic       int_oe;
	logic       glitch;
	logic [7:0] d0;
	logic [7:0] d1;
	logic [3:0] wacks;
	logic [2:0] racks;
	int         err_count;
	int         checked;

	// Pull-ups on the open-drain lines, pins follow whoever drives them
	wire        sda_wire = !(sda_pull || sda_oe);
	wire        int_wire = !int_oe;
	wire  [7:0] lo_pin   = (lo_oe & lo_o) | (~lo_oe & ext_lo);
	wire  [7:0] hi_pin   = (hi_oe & hi_o) | (~hi_oe & ext_hi);

	ioxp_top #(.SLAVE_ADDR_HI(ioxp_pkg::ADDR_HI), .LINK_NS(30)) ioxp_top_inst (
		.REF_CLK_I(ref_clk), .RESETN_I(resetn), .LINK_CLK_I(link_clk),
		.SCL_I(scl), .SDA_I(sda_wire), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
		.ADDR_STRAP_BIT0_I(strap[0]), .ADDR_STRAP_BIT1_I(strap[1]),
		.ADDR_STRAP_BIT2_I(strap[2]), .GPIO_LO_PIN_I(lo_pin), .GPIO_LO_PIN_O(lo_o),
		.GPIO_LO_PIN_OE_O(lo_oe), .GPIO_HI_PIN_I(hi_pin), .GPIO_HI_PIN_O(hi_o),
		.GPIO_HI_PIN_OE_O(hi_oe), .INT_N_O(int_n), .INT_N_OE_O(int_oe));

	ioxp_master_model ioxp_master_model_inst (
		.link_clk_i(link_clk), .sda_i(sda_wire), .scl_o(scl), .sda_low_o(sda_pull));

	// ==========================================================
	// Clocks, watchdog and verdict
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end

	initial
	begin
		#800_000;
		err_count++;
		stop_test();
	end

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
		begin
			$display("TB: PASS");
		end
		else
		begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wait_ref(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		glitch = 1'b0;
		repeat (40)
		begin
			@(negedge ref_clk);
			// Bus line may be unknown until the link domain has seen reset
			glitch = glitch | ((|{lo_oe, hi_oe, int_oe}) !== 1'b0) | (sda_oe === 1'b1);
		end
		@(posedge ref_clk);
		resetn <= 1'b1;
		wait_ref(60);
		`CHK(glitch, 1'b0)
		`CHK({lo_oe, hi_oe}, 16'h0000)
		`CHK({lo_o, hi_o}, {ioxp_pkg::OUT_RST, ioxp_pkg::OUT_RST})
		`CHK({sda_o, int_n, int_oe, int_wire}, 4'h1)
	endtask

	task automatic t_defaults();
		ioxp_master_model_inst.read_pair(DEV, ioxp_pkg::REG_CFG0, d0, d1, racks);
		`CHK(racks, 3'h0)
		`CHK({d0, d1}, {ioxp_pkg::CFG_RST, ioxp_pkg::CFG_RST})
	endtask

	task automatic t_wrong_addr();
		ioxp_master_model_inst.write_pair(DEV ^ 7'h01, ioxp_pkg::REG_OUT0, 8'h00, 8'h00, wacks);
		`CHK(wacks, 4'hF)
		`CHK({lo_o, hi_o}, 16'hFFFF)
	endtask

	task automatic t_outputs();
		ioxp_master_model_inst.write_pair(DEV, ioxp_pkg::REG_OUT0, 8'hA5, 8'h3C, wacks);
		wait_ref(20);
		`CHK(wacks, 4'h0)
		`CHK({lo_o, hi_o}, 16'hA53C)
		`CHK({lo_oe, hi_oe}, 16'h0000)
		ioxp_master_model_inst.write_pair(DEV, ioxp_pkg::REG_CFG0, 8'h00, 8'hF0, wacks);
		wait_ref(20);
		`CHK({lo_oe, hi_oe}, 16'hFF0F)
		`CHK({lo_o, hi_o}, 16'hA53C)
		`CHK(int_oe, 1'b0)
	endtask

	task automatic t_interrupt();
		ioxp_master_model_inst.write_pair(DEV, ioxp_pkg::REG_POL0, 8'h00, 8'hFF, wacks);
		ioxp_master_model_inst.write_pair(DEV, ioxp_pkg::REG_IN0, 8'h00, 8'h00, wacks);
		`CHK(wacks, 4'h0)
		@(posedge ref_clk);
		ext_hi <= 8'hBC;
		wait_ref(10);
		`CHK({int_oe, int_wire}, 2'b10)
		ext_hi <= 8'h3C;
		wait_ref(10);
		`CHK({int_oe, int_wire}, 2'b01)
		ext_hi <= 8'hBC;
		wait_ref(10);
		`CHK(int_oe, 1'b1)
	endtask

	task automatic t_input_read();
		ioxp_master_model_inst.read_pair(DEV, ioxp_pkg::REG_IN0, d0, d1, racks);
		wait_ref(20);
		`CHK(d0, 8'hA5)
		`CHK(d1, ~8'hBC)
		`CHK(int_oe, 1'b0)
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		err_count = 0;
		checked   = 0;
		resetn    = 1'b0;
		strap     = 3'b101;
		ext_lo    = 8'hA5;
		ext_hi    = 8'h3C;
		t_reset();
		t_defaults();
		t_wrong_addr();
		t_outputs();
		t_interrupt();
		t_input_read();
		stop_test();
	end
endmodule
